// ### rtl/tpm_pkg.sv
// Package for the transceiver protection and mode logic
package tpm_pkg;

   localparam int unsigned CLK_MHZ          = 125;
   localparam int unsigned RECOVERY_TIME_US = 200;
   localparam int unsigned RECOVERY_CYCLES  = RECOVERY_TIME_US * CLK_MHZ;
   localparam int unsigned FILTER_TIME_US   = 100;
   localparam int unsigned FILTER_CYCLES    = FILTER_TIME_US * CLK_MHZ;
   localparam int unsigned CNT_W            = 16;

   localparam logic [5:0] ADDR_IRQ_STATUS = 6'h00;
   localparam logic [5:0] ADDR_IRQ_MASK   = 6'h04;
   localparam logic [5:0] ADDR_STATE      = 6'h08;
   localparam logic [5:0] ADDR_CONTROL    = 6'h0C;

   localparam logic [3:0]  IRQ_MASK_RST = 4'h0;
   localparam logic [1:0]  CTRL_RST     = 2'h0;
   localparam int unsigned IRQ_TSD      = 0;
   localparam int unsigned IRQ_BATT     = 1;
   localparam int unsigned IRQ_CORE     = 2;
   localparam int unsigned IRQ_IO       = 3;

   typedef enum logic [2:0] {
      MODE_NORMAL    = 3'b000,
      MODE_SILENT    = 3'b001,
      MODE_STANDBY   = 3'b010,
      MODE_SLEEP     = 3'b011,
      MODE_PROTECTED = 3'b100
   } tpm_mode_e;

   typedef struct packed {
      logic txd;
      logic en;
      logic standby_select_n;
      logic inhibit_suppress;
      logic over_temp;
      logic under_release;
      logic battery_supply_low;
      logic core_supply_low;
      logic io_supply_low;
      logic bus_rx;
   } tpm_pins_s;

   typedef struct packed {
      tpm_pins_s  s1;
      tpm_pins_s  s2;
      tpm_pins_s  s3;
      tpm_pins_s  v;
      tpm_mode_e  mode;
      logic       thermal_shutdown;
      logic       core_flag;
      logic       io_flag;
      logic       recovering;
      logic       uv_sleep;
      logic [CNT_W-1:0] core_cnt;
      logic [CNT_W-1:0] io_cnt;
      logic [CNT_W-1:0] rec_cnt;
      logic       stb_prev;
      logic       inh_latched;
      logic [3:0] irq_status;
      logic [3:0] irq_mask;
      logic [1:0] ctrl;
      logic       bus_drive;
      logic       bus_txd;
      logic       bias;
      logic       rxd;
      logic       rxd_oe;
      logic       fault_indicator_n;
      logic       wake_enable;
      logic       irq;
      logic       pready;
      logic [31:0] prdata;
      logic       pslverr;
   } tpm_state_s;

endpackage : tpm_pkg

// ### rtl/tpm_protection.sv
// Protection, undervoltage and mode logic of the bus transceiver
// Summary of operation
// [RULE_01] Over-temperature turns the bus driver off; transmit data stops reaching bus.
// [RULE_02] During thermal shutdown bus stays recessive, receive output still mirrors bus.
// [RULE_03] Shutdown clears only below release level; re-trips when trip level exceeded.
// [RULE_04] Fault output held low for the whole thermal shutdown.
// [RULE_05] Any supply undervoltage puts bus pins into a no-load protected condition; core undervoltage in normal or silent mode biases the bus instead.
// [RULE_06] Battery undervoltage in any mode forces bus-off: driver and receiver disabled.
// [RULE_07] Core undervoltage keeps normal or silent mode, bus goes autonomous bias.
// [RULE_08] Core undervoltage holds receive output high with I/O supply; wake detection off.
// [RULE_09] I/O supply undervoltage moves device to standby mode.
// [RULE_10] Core or I/O undervoltage beyond filter time moves device to sleep.
// [RULE_11] After supplies return, normal operation resumes after 200 us recovery delay.
// [RULE_12] Undriven inputs read as: transmit recessive, enable low, standby low, inhibit off.
// [RULE_13] Leaving undervoltage sleep needs standby-select rising; enable picks normal or silent.
// [RULE_14] Core and I/O flags set only after low level outlasts filter time.
// [RULE_15] Filter timer restarts when the supply recovers before expiry.
`timescale 1ns/10ps
module tpm_protection
   import tpm_pkg::*;
#(
   parameter int unsigned RECOVERY_CNT = RECOVERY_CYCLES,
   parameter int unsigned FILTER_CNT   = FILTER_CYCLES
) (
   input  wire logic        MCLK_IN,             // System clock, 125 MHz
   input  wire logic        ARST_N_IN,           // Asynchronous reset, active low
   input  wire logic        TXD_IN,              // Transmit data from controller
   input  wire logic        TXD_OE_IN,           // High while controller drives transmit
   input  wire logic        EN_IN,               // Enable pin level
   input  wire logic        EN_OE_IN,            // High while enable is driven
   input  wire logic        STANDBY_SELECT_N_IN, // Standby-select pin level
   input  wire logic        STANDBY_SELECT_OE_IN,// High while standby-select is driven
   input  wire logic        INHIBIT_SUPPRESS_IN, // Inhibit-mask pin level
   input  wire logic        INHIBIT_OE_IN,       // High while inhibit-mask is driven
   input  wire logic        OVER_TEMP_IN,        // Temperature above trip level
   input  wire logic        UNDER_RELEASE_IN,    // Temperature below release level
   input  wire logic        BATTERY_LOW_IN,      // Battery supply below threshold
   input  wire logic        CORE_LOW_IN,         // Core supply below threshold
   input  wire logic        IO_LOW_IN,           // I/O supply below threshold
   input  wire logic        BUS_RX_IN,           // Received bus state, 1 recessive
   input  wire logic        PSEL_IN,             // APB select
   input  wire logic        PENABLE_IN,          // APB enable
   input  wire logic        PWRITE_IN,           // APB direction
   input  wire logic [5:0]  PADDR_IN,            // APB byte address
   input  wire logic [31:0] PWDATA_IN,           // APB write data
   output logic             PREADY_OUT,          // APB ready
   output logic [31:0]      PRDATA_OUT,          // APB read data
   output logic             PSLVERR_OUT,         // APB error, unmapped address
   output logic             BUS_DRIVE_OUT,       // Bus driver enabled
   output logic             BUS_TXD_OUT,         // Level driven to bus, 1 recessive
   output logic             BUS_BIAS_OUT,        // Autonomous bias active
   output logic             RXD_OUT,             // Receive output level
   output logic             RXD_OE_OUT,          // Receive output driven
   output logic             FAULT_INDICATOR_N_OUT,// Fault output, active low
   output logic             WAKE_ENABLE_OUT,     // Wake-up detection active
   output logic [2:0]       MODE_OUT,            // Operating mode code
   output logic             IRQ_OUT              // Level interrupt
);

   tpm_state_s q;
   tpm_state_s d;
   tpm_pins_s  raw;

   always_comb begin
      raw = '{
         txd:                TXD_IN | ~TXD_OE_IN,                           // [RULE_12]
         en:                 EN_IN & EN_OE_IN,                              // [RULE_12]
         standby_select_n:   STANDBY_SELECT_N_IN & STANDBY_SELECT_OE_IN,    // [RULE_12]
         inhibit_suppress:   INHIBIT_SUPPRESS_IN & INHIBIT_OE_IN,           // [RULE_12]
         over_temp:          OVER_TEMP_IN,
         under_release:      UNDER_RELEASE_IN,
         battery_supply_low: BATTERY_LOW_IN,
         core_supply_low:    CORE_LOW_IN,
         io_supply_low:      IO_LOW_IN,
         bus_rx:             BUS_RX_IN
      };
   end

   function automatic logic [CNT_W-1:0] filt_next(input logic low,
                                                  input logic [CNT_W-1:0] cnt);
      if (!low) begin
         filt_next = '0;                                                    // [RULE_15]
      end else if (cnt < CNT_W'(FILTER_CNT)) begin
         filt_next = cnt + CNT_W'(1);
      end else begin
         filt_next = cnt;
      end
   endfunction

   logic       any_uv;
   logic       wr;
   logic       rd;
   logic [3:0] ev;

   always_comb begin
      d      = q;
      wr     = PSEL_IN & PENABLE_IN & PWRITE_IN;
      rd     = PSEL_IN & ~PENABLE_IN & ~PWRITE_IN;
      ev     = '0;
      // Three-stage sampling, value moves once stages two and three agree
      // Only stage two reads stage one, so a metastable first stage never reaches logic
      d.s1   = raw;
      d.s2   = q.s1;
      d.s3   = q.s2;
      for (int i = 0; i < $bits(tpm_pins_s); i++) begin
         if (q.s2[i] == q.s3[i]) begin
            d.v[i] = q.s3[i];
         end
      end

      // Thermal shutdown with hysteresis
      if (q.v.over_temp && !q.thermal_shutdown) begin
         d.thermal_shutdown = 1'b1;                                         // [RULE_01] [RULE_03]
         ev[IRQ_TSD]        = 1'b1;
      end else if (q.thermal_shutdown && q.v.under_release && !q.v.over_temp) begin
         d.thermal_shutdown = 1'b0;                                         // [RULE_03]
      end

      // Undervoltage filters
      d.core_cnt  = filt_next(q.v.core_supply_low, q.core_cnt);             // [RULE_14]
      d.io_cnt    = filt_next(q.v.io_supply_low, q.io_cnt);                 // [RULE_14]
      d.core_flag = (q.core_cnt >= CNT_W'(FILTER_CNT)) & q.v.core_supply_low; // [RULE_14]
      d.io_flag   = (q.io_cnt >= CNT_W'(FILTER_CNT)) & q.v.io_supply_low;   // [RULE_14]
      ev[IRQ_BATT] = q.v.battery_supply_low & (q.mode != MODE_PROTECTED);
      ev[IRQ_CORE] = d.core_flag & ~q.core_flag;
      ev[IRQ_IO]   = d.io_flag & ~q.io_flag;

      any_uv     = q.v.battery_supply_low | q.v.core_supply_low | q.v.io_supply_low;
      d.stb_prev = q.v.standby_select_n;

      // Mode sequencing
      if (q.v.battery_supply_low) begin
         d.mode       = MODE_PROTECTED;                                     // [RULE_06]
         d.recovering = 1'b1;
         d.rec_cnt    = '0;
         d.uv_sleep   = 1'b0;
         d.inh_latched = 1'b0;
      end else if (q.core_flag || q.io_flag) begin
         d.mode       = MODE_SLEEP;                                         // [RULE_10]
         d.uv_sleep   = 1'b1;
         d.recovering = 1'b0;
      end else if (q.v.io_supply_low && q.mode != MODE_SLEEP) begin
         d.mode       = MODE_STANDBY;                                       // [RULE_09]
         d.recovering = 1'b1;
         d.rec_cnt    = '0;
      end else if (q.mode == MODE_SLEEP) begin
         if (q.uv_sleep && !q.v.io_supply_low && q.v.standby_select_n && !q.stb_prev) begin
            d.mode     = q.v.en ? MODE_NORMAL : MODE_SILENT;                // [RULE_13]
            d.uv_sleep = 1'b0;
         end
      end else if (q.v.core_supply_low) begin
         d.recovering = 1'b1;                                               // [RULE_07]
         d.rec_cnt    = '0;
      end else if (q.recovering) begin
         if (q.rec_cnt >= CNT_W'(RECOVERY_CNT - 1)) begin
            d.recovering = 1'b0;                                            // [RULE_11]
            d.mode       = MODE_STANDBY;
         end else begin
            d.rec_cnt = q.rec_cnt + CNT_W'(1);                              // [RULE_11]
         end
      end else begin
         unique case ({q.v.standby_select_n, q.v.en})
            2'b11:   d.mode = MODE_NORMAL;
            2'b10:   d.mode = MODE_SILENT;
            default: d.mode = MODE_STANDBY;
         endcase
      end
      if (q.mode == MODE_SILENT) begin
         d.inh_latched = q.v.inhibit_suppress;
      end

      // Bus and receive path
      d.bias      = q.v.core_supply_low & ~q.v.battery_supply_low
                    & (q.mode == MODE_NORMAL || q.mode == MODE_SILENT);     // [RULE_07]
      d.bus_drive = (q.mode == MODE_NORMAL) & ~q.thermal_shutdown & ~any_uv
                    & ~q.recovering & ~d.thermal_shutdown;                  // [RULE_01] [RULE_05]
      d.bus_txd   = d.bus_drive ? q.v.txd : 1'b1;                           // [RULE_02]
      d.rxd_oe    = ~q.v.battery_supply_low & ~q.v.io_supply_low;           // [RULE_06]
      if (q.v.core_supply_low) begin
         d.rxd = 1'b1;                                                      // [RULE_08]
      end else if (q.mode == MODE_NORMAL || q.mode == MODE_SILENT) begin
         d.rxd = q.v.bus_rx;                                                // [RULE_02]
      end else begin
         d.rxd = 1'b1;
      end
      d.wake_enable = ~q.v.core_supply_low & ~q.v.battery_supply_low
                      & (q.mode == MODE_STANDBY || q.mode == MODE_SLEEP);   // [RULE_08]
      d.fault_indicator_n = ~q.thermal_shutdown;                            // [RULE_04]

      // Register bus: no wait states, reads prepared in setup
      d.pready  = PSEL_IN & ~PENABLE_IN;
      d.pslverr = 1'b0;
      if (PSEL_IN && !PENABLE_IN) begin
         d.prdata = '0;
         unique case (PADDR_IN)
            ADDR_IRQ_STATUS: d.prdata[3:0] = q.irq_status;
            ADDR_IRQ_MASK:   d.prdata[3:0] = q.irq_mask;
            ADDR_STATE:      d.prdata[7:0] = {q.inh_latched, q.io_flag, q.core_flag,
                                              q.thermal_shutdown, q.recovering, q.mode};
            ADDR_CONTROL:    d.prdata[1:0] = q.ctrl;
            default:         d.pslverr     = 1'b1;
         endcase
         if (!rd) begin
            d.prdata = '0;
         end
      end
      if (wr && q.pready) begin
         unique case (PADDR_IN)
            ADDR_IRQ_STATUS: d.irq_status = q.irq_status & ~PWDATA_IN[3:0];
            ADDR_IRQ_MASK:   d.irq_mask   = PWDATA_IN[3:0];
            ADDR_CONTROL:    d.ctrl       = PWDATA_IN[1:0];
            default:         d.ctrl       = q.ctrl;
         endcase
      end
      d.irq_status = d.irq_status | ev;
      d.irq        = |(q.irq_status & ~q.irq_mask);
      if (q.ctrl[0]) begin
         d.bus_drive = 1'b0;
         d.bus_txd   = 1'b1;
      end
   end

   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         q                   <= '0;
         q.s1.txd            <= 1'b1;
         q.s1.bus_rx         <= 1'b1;
         q.s2.txd            <= 1'b1;
         q.s3.txd            <= 1'b1;
         q.v.txd             <= 1'b1;
         q.s2.bus_rx         <= 1'b1;
         q.s3.bus_rx         <= 1'b1;
         q.v.bus_rx          <= 1'b1;
         q.mode              <= MODE_STANDBY;
         q.recovering        <= 1'b1;
         q.irq_mask          <= IRQ_MASK_RST;
         q.ctrl              <= CTRL_RST;
         q.bus_txd           <= 1'b1;
         q.rxd               <= 1'b1;
         q.fault_indicator_n <= 1'b1;
      end else begin
         q <= d;
      end
   end

   assign PREADY_OUT            = q.pready;
   assign PRDATA_OUT            = q.prdata;
   assign PSLVERR_OUT           = q.pslverr;
   assign BUS_DRIVE_OUT         = q.bus_drive;
   assign BUS_TXD_OUT           = q.bus_txd;
   assign BUS_BIAS_OUT          = q.bias;
   assign RXD_OUT               = q.rxd;
   assign RXD_OE_OUT            = q.rxd_oe;
   assign FAULT_INDICATOR_N_OUT = q.fault_indicator_n;
   assign WAKE_ENABLE_OUT       = q.wake_enable;
   assign MODE_OUT              = q.mode;
   assign IRQ_OUT               = q.irq;

endmodule // tpm_protection

// ### dv/tpm_protection_monitor.sv
// Concurrent checks on the ports of the protection block
`timescale 1ns/10ps
module tpm_protection_monitor
   import tpm_pkg::*;
#(
   parameter int unsigned RECOVERY_CNT = 20,
   parameter int unsigned FILTER_CNT   = 10
) (
   input wire logic       MCLK_IN, ARST_N_IN,                      // Clock, reset
   input wire logic       OVER_TEMP_IN, UNDER_RELEASE_IN,          // Temperature
   input wire logic       BATTERY_LOW_IN, CORE_LOW_IN, IO_LOW_IN,  // Supplies
   input wire logic       PSEL_IN, PENABLE_IN, PREADY_OUT,         // Bus handshake
   input wire logic       BUS_DRIVE_OUT, BUS_TXD_OUT, BUS_BIAS_OUT, // Bus side
   input wire logic       RXD_OUT, RXD_OE_OUT, WAKE_ENABLE_OUT,    // Receive side
   input wire logic       FAULT_INDICATOR_N_OUT,                   // Fault
   input wire logic [2:0] MODE_OUT                                 // Mode
);
   logic [3:0]  rel_age_q;
   logic [15:0] lo_cnt_q;
   logic [15:0] ok_cnt_q;
   // Cycles since release level, length of supply drop, length of good supplies
   always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
      if (!ARST_N_IN) begin
         rel_age_q <= 4'hF;
         lo_cnt_q  <= 16'h0;
         ok_cnt_q  <= 16'h0;
      end else begin
         rel_age_q <= UNDER_RELEASE_IN ? 4'h0 : rel_age_q + {3'h0, rel_age_q != 4'hF};
         lo_cnt_q  <= (CORE_LOW_IN || IO_LOW_IN) ? lo_cnt_q + 16'h1 : 16'h0;
         ok_cnt_q  <= (CORE_LOW_IN || IO_LOW_IN || BATTERY_LOW_IN) ? 16'h0 : ok_cnt_q + 16'h1;
      end
   end
   default clocking cb @(posedge MCLK_IN); endclocking
   default disable iff (!ARST_N_IN);
   sequence s_held(sig);
      $rose(sig) ##1 sig[*3];
   endsequence
   a_tsd_entry: assert property (s_held(OVER_TEMP_IN) |-> ##[1:6]
      (!BUS_DRIVE_OUT && !FAULT_INDICATOR_N_OUT)) else $error("shutdown late");
   a_tsd_recessive: assert property (!FAULT_INDICATOR_N_OUT |->
      (!BUS_DRIVE_OUT && BUS_TXD_OUT)) else $error("bus not recessive");
   a_tsd_release: assert property ($rose(FAULT_INDICATOR_N_OUT) |->
      rel_age_q < 4'h8) else $error("fault cleared early");
   a_batt_bus_off: assert property (s_held(BATTERY_LOW_IN) |-> ##[1:5]
      (MODE_OUT == MODE_PROTECTED && !RXD_OE_OUT && !BUS_DRIVE_OUT)) else $error("no bus-off");
   a_core_bias_hold: assert property ((MODE_OUT == MODE_NORMAL && !IO_LOW_IN) ##0
      s_held(CORE_LOW_IN) |-> ##[1:5] (BUS_BIAS_OUT && RXD_OUT && !WAKE_ENABLE_OUT
      && MODE_OUT == MODE_NORMAL)) else $error("no bias on core drop");
   a_io_standby: assert property (s_held(IO_LOW_IN) |-> ##[1:5] MODE_OUT == MODE_STANDBY)
      else $error("no standby");
   a_sleep_filter: assert property ($rose(MODE_OUT == MODE_SLEEP) |->
      lo_cnt_q >= FILTER_CNT) else $error("sleep too soon");
   a_sleep_due: assert property (lo_cnt_q == FILTER_CNT + 10 |-> MODE_OUT == MODE_SLEEP)
      else $error("sleep missing");
   a_recover_wait: assert property ($rose(MODE_OUT == MODE_NORMAL) |->
      ok_cnt_q >= RECOVERY_CNT - 2) else $error("normal too soon");
   a_apb_ready: assert property (PSEL_IN && !PENABLE_IN |=> PREADY_OUT) else $error("no ready");
endmodule // tpm_protection_monitor

bind tpm_protection tpm_protection_monitor #(.RECOVERY_CNT(RECOVERY_CNT), .FILTER_CNT(FILTER_CNT))
   u_mon (.MCLK_IN(MCLK_IN), .ARST_N_IN(ARST_N_IN), .OVER_TEMP_IN(OVER_TEMP_IN),
   .UNDER_RELEASE_IN(UNDER_RELEASE_IN), .BATTERY_LOW_IN(BATTERY_LOW_IN),
   .CORE_LOW_IN(CORE_LOW_IN), .IO_LOW_IN(IO_LOW_IN), .PSEL_IN(PSEL_IN),
   .PENABLE_IN(PENABLE_IN), .PREADY_OUT(PREADY_OUT), .BUS_DRIVE_OUT(BUS_DRIVE_OUT),
   .BUS_TXD_OUT(BUS_TXD_OUT), .BUS_BIAS_OUT(BUS_BIAS_OUT), .RXD_OUT(RXD_OUT),
   .RXD_OE_OUT(RXD_OE_OUT), .WAKE_ENABLE_OUT(WAKE_ENABLE_OUT),
   .FAULT_INDICATOR_N_OUT(FAULT_INDICATOR_N_OUT), .MODE_OUT(MODE_OUT));

// ### dv/tpm_ctrl_model.sv
// Behavioural protocol controller driving the transceiver control pins
`timescale 1ns/10ps
module tpm_ctrl_model (
   input  wire logic       clk_in,  // Clock
   output logic      [3:0] lvl_out, // Levels: inhibit, standby-select, enable, transmit
   output logic      [3:0] oe_out   // Drive enables, same order
);
   logic [3:0] lvl_q  = 4'h0;
   logic [3:0] oe_q   = 4'h0;
   logic       flip_q = 1'b0;
   always_ff @(posedge clk_in) begin
      flip_q <= ~flip_q;
   end
   // A released pin shows a level that changes every cycle
   assign lvl_out = (lvl_q & oe_q) | ({4{flip_q}} & ~oe_q);
   assign oe_out  = oe_q;
   task automatic drive(input logic [3:0] lvl, input logic [3:0] oe);
      @(posedge clk_in);
      lvl_q <= lvl;
      oe_q  <= oe;
   endtask
   // Standby-select low, then high; enable picks the mode at the edge
   task automatic wake(input logic en);
      drive({2'b00, en, 1'b1}, 4'hF);
      repeat (6) @(posedge clk_in);
      drive({2'b01, en, 1'b1}, 4'hF);
   endtask
endmodule // tpm_ctrl_model

// ### dv/testbench.sv
// Self-checking bench for the protection and mode block
`timescale 1ns/10ps
module testbench
   import tpm_pkg::*;
;
   localparam int unsigned REC = 20;
   localparam int unsigned FLT = 10;
   logic        clk, rst_n = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
   logic        pready, pslverr, perr, drive, btxd, bias, rxd, rxd_oe, fault_n, wake, irq;
   logic        ot = 1'b0, rel = 1'b1, batt = 1'b0, core_lo = 1'b0, io_lo = 1'b0, bus_rx = 1'b1;
   logic [5:0]  paddr = 6'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd, v, seed = 32'd96;
   logic [3:0]  lvl, oe;
   logic [2:0]  mode;
   int          n_errors = 0, num_checks = 0, exp_stat = 0;
   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   tpm_protection #(.RECOVERY_CNT(REC), .FILTER_CNT(FLT)) u_dut (
      .MCLK_IN(clk), .ARST_N_IN(rst_n), .TXD_IN(lvl[0]), .TXD_OE_IN(oe[0]),
      .EN_IN(lvl[1]), .EN_OE_IN(oe[1]), .STANDBY_SELECT_N_IN(lvl[2]),
      .STANDBY_SELECT_OE_IN(oe[2]), .INHIBIT_SUPPRESS_IN(lvl[3]), .INHIBIT_OE_IN(oe[3]),
      .OVER_TEMP_IN(ot), .UNDER_RELEASE_IN(rel), .BATTERY_LOW_IN(batt),
      .CORE_LOW_IN(core_lo), .IO_LOW_IN(io_lo), .BUS_RX_IN(bus_rx), .PSEL_IN(psel),
      .PENABLE_IN(penable), .PWRITE_IN(pwrite), .PADDR_IN(paddr), .PWDATA_IN(pwdata),
      .PREADY_OUT(pready), .PRDATA_OUT(prdata), .PSLVERR_OUT(pslverr),
      .BUS_DRIVE_OUT(drive), .BUS_TXD_OUT(btxd), .BUS_BIAS_OUT(bias), .RXD_OUT(rxd),
      .RXD_OE_OUT(rxd_oe), .FAULT_INDICATOR_N_OUT(fault_n), .WAKE_ENABLE_OUT(wake),
      .MODE_OUT(mode), .IRQ_OUT(irq));
   tpm_ctrl_model u_ctrl (.clk_in(clk), .lvl_out(lvl), .oe_out(oe));
   function automatic logic [31:0] xs();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %0h expected %0h", $time, got, exp);
      end
   endtask
   task automatic chk1(input logic got, input logic exp);
      check({31'h0, got}, {31'h0, exp});
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic apb(input logic wr, input logic [5:0] a, input logic [31:0] wd);
      int n;
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= wd;
      @(posedge clk);
      penable <= 1'b1;
      do begin
         @(posedge clk);
         n++;
      end while (pready !== 1'b1 && n < 20);
      chk1(pready, 1'b1);
      rd = prdata;
      perr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic rd_chk(input logic [5:0] a, input logic [31:0] e, input logic pe);
      apb(1'b0, a, 32'h0);
      check(rd, e);
      chk1(perr, pe);
   endtask
   task automatic want_mode(input tpm_mode_e m, input int lim);
      int n;
      n = 0;
      while (mode !== m && n < lim) begin
         @(posedge clk);
         n++;
      end
      check({29'h0, mode}, {29'h0, m});
   endtask
   task automatic close_out();
      $display("checks %0d errors %0d", num_checks, n_errors);
      if (n_errors == 0 && num_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask
   initial begin
      cyc(20000);
      n_errors++;
      close_out();
   end
   initial begin
      u_ctrl.drive(4'b0111, 4'hF);
      cyc(2);
      rst_n <= 1'b1;
      cyc(REC / 2);
      want_mode(MODE_STANDBY, 0);
      chk1(wake, 1'b1);
      want_mode(MODE_NORMAL, REC + 10);
      chk1(rxd_oe, 1'b1);
      rd_chk(ADDR_IRQ_MASK, {28'h0, IRQ_MASK_RST}, 1'b0);
      rd_chk(ADDR_CONTROL, {30'h0, CTRL_RST}, 1'b0);
      rd_chk(ADDR_STATE, 32'h0, 1'b0);
      apb(1'b1, 6'h10, 32'hFFFFFFFF);
      rd_chk(6'h10, 32'h0, 1'b1);
      apb(1'b1, ADDR_IRQ_MASK, 32'hFFFFFFFF);
      rd_chk(ADDR_IRQ_MASK, 32'hF, 1'b0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      apb(1'b1, ADDR_CONTROL, 32'h1);
      cyc(3);
      chk1(drive, 1'b0);
      apb(1'b1, ADDR_CONTROL, 32'h0);
      for (int i = 0; i < 6; i++) begin
         v = xs();
         u_ctrl.drive({3'b011, v[0]}, 4'hF);
         bus_rx <= v[1];
         cyc(8);
         chk1(btxd, v[0]);
         chk1(rxd, v[1]);
      end
      u_ctrl.drive(4'b0110, 4'hF);
      cyc(8);
      u_ctrl.drive(4'b0110, 4'hE);
      cyc(8);
      chk1(btxd, 1'b1);
      u_ctrl.drive(4'b0110, 4'hF);
      rel <= 1'b0;
      ot <= 1'b1;
      cyc(10);
      chk1(fault_n, 1'b0);
      chk1(btxd, 1'b1);
      bus_rx <= 1'b0;
      cyc(8);
      chk1(rxd, 1'b0);
      exp_stat = 1;
      chk1(irq, 1'b1);
      rd_chk(ADDR_IRQ_STATUS, exp_stat, 1'b0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h1);
      cyc(2);
      chk1(irq, 1'b0);
      apb(1'b1, ADDR_IRQ_MASK, 32'h0);
      for (int i = 0; i < 2; i++) begin
         ot <= 1'b0;
         cyc(10);
         chk1(fault_n, 1'b0);
         rel <= 1'b1;
         cyc(10);
         chk1(fault_n, 1'b1);
         chk1(btxd, 1'b0);
         rel <= 1'b0;
         ot <= 1'b1;
         cyc(10);
         chk1(fault_n, 1'b0);
      end
      ot <= 1'b0;
      rel <= 1'b1;
      u_ctrl.drive(4'b0111, 4'hF);
      cyc(10);
      apb(1'b1, ADDR_IRQ_STATUS, 32'h1);
      exp_stat = 0;
      rd_chk(ADDR_IRQ_STATUS, exp_stat, 1'b0);
      chk1(irq, 1'b0);
      repeat (3) begin
         core_lo <= 1'b1;
         cyc(FLT - 3);
         chk1(bias, 1'b1);
         chk1(rxd, 1'b1);
         chk1(wake, 1'b0);
         core_lo <= 1'b0;
         cyc(3);
      end
      want_mode(MODE_NORMAL, 0);
      for (int i = 0; i < 2; i++) begin
         if (i == 0) core_lo <= 1'b1;
         else io_lo <= 1'b1;
         if (i == 1) want_mode(MODE_STANDBY, 8);
         want_mode(MODE_SLEEP, FLT + 12);
         cyc(4);
         core_lo <= 1'b0;
         io_lo <= 1'b0;
         cyc(REC + 10);
         want_mode(MODE_SLEEP, 0);
         u_ctrl.wake(i[0]);
         want_mode(i == 1 ? MODE_NORMAL : MODE_SILENT, 10);
      end
      batt <= 1'b1;
      want_mode(MODE_PROTECTED, 8);
      chk1(rxd_oe, 1'b0);
      chk1(drive, 1'b0);
      batt <= 1'b0;
      cyc(REC / 2);
      chk1(mode == MODE_NORMAL, 1'b0);
      want_mode(MODE_NORMAL, REC + 12);
      exp_stat = 14;
      rd_chk(ADDR_IRQ_STATUS, exp_stat, 1'b0);
      chk1(irq, 1'b1);
      apb(1'b1, ADDR_IRQ_STATUS, 32'hF);
      rd_chk(ADDR_IRQ_STATUS, 32'h0, 1'b0);
      u_ctrl.drive(4'b1111, 4'h5);
      want_mode(MODE_SILENT, 10);
      rd_chk(ADDR_STATE, 32'h1, 1'b0);
      u_ctrl.drive(4'b0111, 4'h0);
      want_mode(MODE_STANDBY, 10);
      close_out();
   end
endmodule // testbench
